/* File: core/ptpc_map.vh */
// Purpose: Register map and constants for the port T pin control block.
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register.
// Notes:   Offsets, field positions and reset values live here only.
`ifndef PTPC_MAP_VH
`define PTPC_MAP_VH

// ====================
// Register byte offsets
`define PTPC_OFS_PORT_T_OUTPUT_VALUE  12'h240
`define PTPC_OFS_PORT_T_DIRECTION     12'h244
`define PTPC_OFS_PIN_MISC_CONTROL     12'h248
`define PTPC_OFS_EXT_IRQ_CONTROL      12'h24C
`define PTPC_OFS_FACTORY_TEST         12'h250
`define PTPC_OFS_EXT_IRQ_STATUS       12'h254

// ====================
// Field positions
`define PTPC_BIT_OVERCURRENT_ENABLE   7
`define PTPC_BIT_IRQ_EDGE_SELECT      7
`define PTPC_BIT_IRQ_CONNECT          6
`define PTPC_BIT_IRQ_PENDING          0

// ====================
// Reset values
`define PTPC_RST_PORT_T_OUTPUT_VALUE  4'h0
`define PTPC_RST_PORT_T_DIRECTION     4'h0
`define PTPC_RST_PIN_MISC_CONTROL     1'b0
`define PTPC_RST_IRQ_EDGE_SELECT      1'b0
`define PTPC_RST_IRQ_CONNECT          1'b0
`define PTPC_RST_FACTORY_TEST         8'h00

// ====================
// Bus responses
`define PTPC_RESP_OKAY                2'h0
`define PTPC_RESP_SLVERR              2'h2

`endif

/* File: core/ptpc_sync.v */
// Purpose: Two-stage synchroniser for a group of asynchronous levels.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Only the second stage may be read outside this module.
`timescale 1ns/1ns

module ptpc_sync #(
    parameter WIDTH = 5
) (
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    // ====================
    // Synchroniser stages
    always @(posedge clk_in) begin
        if (rst_in) begin
            stage_one <= {WIDTH{1'b0}};
            stage_two <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;
endmodule

/* File: core/ptpc_top.v */
// Purpose: Port T data path, external interrupt conditioner, misc control.
// Assumes: Registers over AXI4-Lite; peripheral signals are synchronous inputs, pins and interrupt pin are synchronised here.
// Notes:   Routing select inputs come from routing registers kept elsewhere.
//
// Functional notes
// RULE_01 - Misc bit 7 enables over-current detector.
// RULE_02 - Edge mode: falling edges detected any time; code latches them only while connect bit is set.
// RULE_03 - Latched edge clears only by reset/service; code also clears it on every cycle while edge select is zero.
// RULE_04 - Edge select zero means low level request.
// RULE_05 - Connect bit links interrupt pin to logic.
// RULE_06 - Edge select write once in normal mode.
// RULE_07 - Data read: register if output, else pin.
// RULE_08 - Plain output drives stored data bit.
// RULE_09 - SPI beats LIN, timer, GPIO on bits 3-2.
// RULE_10 - LIN beats timer and GPIO on bits 3-2.
// RULE_11 - Serial or LIN level beats timer on bit 1.
// RULE_12 - Serial beats timer and GPIO on bit 0.
// RULE_13 - Timer beats GPIO when nothing higher active.
// RULE_14 - PWM only if no driver route claims pin.
// RULE_15 - Compare withheld on high-side; capture off LIN receive.
// RULE_16 - Compare withheld on low-side driver pin.
// RULE_17 - Factory register writable in special mode only.
// RULE_18 - Direction one is output unless function forces.
// RULE_19 - Register reads are synchronous to clock.
// RULE_20 - Pins pass a two-stage synchroniser first.
`timescale 1ns/1ns
`include "ptpc_map.vh"

module ptpc_top (
    input  wire        CLOCK_IN,
    input  wire        SYS_RST_IN,
    input  wire        SPECIAL_MODE_IN,

    input  wire [11:0] S_AXI_AWADDR_IN,
    input  wire        S_AXI_AWVALID_IN,
    output wire        S_AXI_AWREADY_OUT,
    input  wire [31:0] S_AXI_WDATA_IN,
    input  wire [3:0]  S_AXI_WSTRB_IN,
    input  wire        S_AXI_WVALID_IN,
    output wire        S_AXI_WREADY_OUT,
    output reg  [1:0]  S_AXI_BRESP_OUT,
    output reg         S_AXI_BVALID_OUT,
    input  wire        S_AXI_BREADY_IN,
    input  wire [11:0] S_AXI_ARADDR_IN,
    input  wire        S_AXI_ARVALID_IN,
    output wire        S_AXI_ARREADY_OUT,
    output reg  [31:0] S_AXI_RDATA_OUT,
    output reg  [1:0]  S_AXI_RRESP_OUT,
    output reg         S_AXI_RVALID_OUT,
    input  wire        S_AXI_RREADY_IN,

    input  wire [3:0]  PORT_T_PIN_IN,
    output wire [3:0]  PORT_T_PIN_OUT,
    output wire [3:0]  PORT_T_PIN_OE_OUT,

    input  wire [3:2]  SPI_ENABLE_IN,
    input  wire [3:2]  SPI_DRIVE_IN,
    input  wire [3:2]  SPI_LEVEL_IN,
    output wire [3:2]  SPI_PIN_OUT,

    input  wire [3:2]  LIN_TRANSCEIVER_ROUTE_IN,
    input  wire [3:2]  LIN_DRIVE_IN,
    input  wire [3:2]  LIN_LEVEL_IN,
    output wire [3:2]  LIN_PIN_OUT,

    input  wire [1:0]  SERIAL_IFACE_ZERO_ROUTE_IN,
    input  wire [1:0]  SERIAL_IFACE_ZERO_DRIVE_IN,
    input  wire [1:0]  SERIAL_IFACE_ZERO_LEVEL_IN,
    output wire [1:0]  SERIAL_IFACE_ZERO_PIN_OUT,

    input  wire        LIN_DRIVER_LEVEL_BIT_ENABLE_IN,
    input  wire        LIN_DRIVER_LEVEL_BIT_IN,

    input  wire [3:0]  TIMER_CHANNEL_COMPARE_EN_IN,
    input  wire [3:0]  TIMER_CHANNEL_COMPARE_IN,
    output wire [3:0]  TIMER_CHANNEL_CAPTURE_OUT,

    input  wire [3:0]  PWM_ENABLE_IN,
    input  wire [3:0]  PWM_LEVEL_IN,
    input  wire [3:0]  HIGH_SIDE_DRIVER_ROUTE_IN,
    input  wire [3:0]  LOW_SIDE_DRIVER_ROUTE_IN,
    input  wire [3:0]  LIN_RECEIVE_PATH_IN,

    input  wire        EXT_IRQ_PIN_IN,
    input  wire        EXT_IRQ_SERVICE_IN,
    output wire        EXT_IRQ_REQUEST_OUT,
    output wire        OVERCURRENT_DETECT_ENABLE_OUT
);
    // ====================
    // Storage

    reg  [3:0] port_t_output_value;
    reg  [3:0] port_t_direction;

    reg        overcurrent_detect_enable;
    reg        ext_irq_edge_select;
    reg        ext_irq_edge_written;
    reg        ext_irq_connect;
    reg  [7:0] factory_test;

    reg        ext_irq_pending;
    reg        irq_level_prev;

    reg        aw_held;
    reg        w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg  [3:0] w_strb;

    wire [4:0] sync_level;
    wire [3:0] pin_sync;
    wire       irq_sync;

    // ====================
    // Input synchronisers

    ptpc_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_in   (CLOCK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in ({EXT_IRQ_PIN_IN, PORT_T_PIN_IN}),
        .sync_out (sync_level)
    ); // RULE_20
    assign pin_sync = sync_level[3:0];
    assign irq_sync = sync_level[4];

    // ====================
    // Pin priority multiplexing

    // Each bit is resolved highest owner first, so lower functions never glitch the pin.
    reg [3:0] pin_drive;
    reg [3:0] pin_oe;
    reg [3:0] alt_owned;
    integer   k;
    always @* begin
        pin_drive = 4'h0;
        pin_oe    = 4'h0;
        alt_owned = 4'h0;

        for (k = 0; k < 4; k = k + 1) begin
            if (k >= 2 && SPI_ENABLE_IN[k]) begin
                pin_drive[k] = SPI_LEVEL_IN[k]; // RULE_09
                pin_oe[k]    = SPI_DRIVE_IN[k];
                alt_owned[k] = 1'b1;
            end else if (k >= 2 && LIN_TRANSCEIVER_ROUTE_IN[k]) begin
                pin_drive[k] = LIN_LEVEL_IN[k]; // RULE_10
                pin_oe[k]    = LIN_DRIVE_IN[k];
                alt_owned[k] = 1'b1;
            end else if (k < 2 && SERIAL_IFACE_ZERO_ROUTE_IN[k]) begin
                pin_drive[k] = SERIAL_IFACE_ZERO_LEVEL_IN[k]; // RULE_11 RULE_12
                pin_oe[k]    = SERIAL_IFACE_ZERO_DRIVE_IN[k];
                alt_owned[k] = 1'b1;
            end else if (k == 1 && LIN_DRIVER_LEVEL_BIT_ENABLE_IN) begin
                pin_drive[k] = LIN_DRIVER_LEVEL_BIT_IN; // RULE_11
                pin_oe[k]    = 1'b1;
                alt_owned[k] = 1'b1;
            end else if (TIMER_CHANNEL_COMPARE_EN_IN[k] && !HIGH_SIDE_DRIVER_ROUTE_IN[k]
                         && !LOW_SIDE_DRIVER_ROUTE_IN[k]) begin
                pin_drive[k] = TIMER_CHANNEL_COMPARE_IN[k]; // RULE_13 RULE_15 RULE_16
                pin_oe[k]    = 1'b1;
                alt_owned[k] = 1'b1;
            end else if (PWM_ENABLE_IN[k] && !HIGH_SIDE_DRIVER_ROUTE_IN[k]
                         && !LOW_SIDE_DRIVER_ROUTE_IN[k]) begin
                pin_drive[k] = PWM_LEVEL_IN[k]; // RULE_14
                pin_oe[k]    = 1'b1;
                alt_owned[k] = 1'b1;
            end else begin
                pin_drive[k] = port_t_output_value[k]; // RULE_08
                pin_oe[k]    = port_t_direction[k]; // RULE_18
            end
        end
    end

    assign PORT_T_PIN_OUT            = pin_drive;
    assign PORT_T_PIN_OE_OUT         = pin_oe;

    assign SPI_PIN_OUT               = pin_sync[3:2];
    assign LIN_PIN_OUT               = pin_sync[3:2];
    assign SERIAL_IFACE_ZERO_PIN_OUT = pin_sync[1:0];
    assign TIMER_CHANNEL_CAPTURE_OUT = pin_sync & ~LIN_RECEIVE_PATH_IN; // RULE_15

    // ====================
    // External interrupt conditioner

    wire irq_falling = irq_level_prev & ~irq_sync;

    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            irq_level_prev  <= 1'b0;
            ext_irq_pending <= 1'b0;
        end else begin
            irq_level_prev <= irq_sync;
            // A new edge in the servicing cycle wins, so it is never lost.
            if (ext_irq_edge_select && ext_irq_connect && irq_falling) begin
                ext_irq_pending <= 1'b1; // RULE_02
            end else if (EXT_IRQ_SERVICE_IN || !ext_irq_edge_select) begin
                ext_irq_pending <= 1'b0; // RULE_03
            end
        end
    end

    assign EXT_IRQ_REQUEST_OUT = ext_irq_connect &
        (ext_irq_edge_select ? ext_irq_pending : ~irq_sync); // RULE_04 RULE_05

    assign OVERCURRENT_DETECT_ENABLE_OUT = overcurrent_detect_enable; // RULE_01

    // ====================
    // AXI4-Lite write channel

    wire [11:0] wr_addr  = S_AXI_AWVALID_IN && !aw_held ? S_AXI_AWADDR_IN : aw_addr;
    wire [31:0] wr_data  = S_AXI_WVALID_IN && !w_held ? S_AXI_WDATA_IN : w_data;
    wire [3:0]  wr_strb  = S_AXI_WVALID_IN && !w_held ? S_AXI_WSTRB_IN : w_strb;

    wire        have_aw  = aw_held | S_AXI_AWVALID_IN;
    wire        have_w   = w_held | S_AXI_WVALID_IN;
    wire        do_write = have_aw && have_w && !S_AXI_BVALID_OUT;
    wire        lane0    = wr_strb[0];

    assign S_AXI_AWREADY_OUT = !aw_held && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT  = !w_held && !S_AXI_BVALID_OUT;

    function addr_known;
        input [11:0] a;
        begin
            addr_known = (a == `PTPC_OFS_PORT_T_OUTPUT_VALUE) ||
                         (a == `PTPC_OFS_PORT_T_DIRECTION) ||
                         (a == `PTPC_OFS_PIN_MISC_CONTROL) ||
                         (a == `PTPC_OFS_EXT_IRQ_CONTROL) ||
                         (a == `PTPC_OFS_FACTORY_TEST) ||
                         (a == `PTPC_OFS_EXT_IRQ_STATUS);
        end
    endfunction

    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            aw_held          <= 1'b0;
            w_held           <= 1'b0;
            aw_addr          <= 12'h000;
            w_data           <= 32'h00000000;
            w_strb           <= 4'h0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT  <= `PTPC_RESP_OKAY;
        end else begin
            if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end

            if (do_write) begin
                aw_held          <= 1'b0;
                w_held           <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT  <= addr_known({wr_addr[11:2], 2'b00}) ?
                                    `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
            end else begin
                if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
                    aw_held <= 1'b1;
                    aw_addr <= S_AXI_AWADDR_IN;
                end
                if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
                    w_held <= 1'b1;
                    w_data <= S_AXI_WDATA_IN;
                    w_strb <= S_AXI_WSTRB_IN;
                end
            end
        end
    end

    // ====================
    // Register updates

    wire [11:0] wr_word = {wr_addr[11:2], 2'b00};

    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            port_t_output_value       <= `PTPC_RST_PORT_T_OUTPUT_VALUE;
            port_t_direction          <= `PTPC_RST_PORT_T_DIRECTION;
            overcurrent_detect_enable <= `PTPC_RST_PIN_MISC_CONTROL;
            ext_irq_edge_select       <= `PTPC_RST_IRQ_EDGE_SELECT;
            ext_irq_edge_written      <= 1'b0;
            ext_irq_connect           <= `PTPC_RST_IRQ_CONNECT;
            factory_test              <= `PTPC_RST_FACTORY_TEST;
        end else if (do_write && lane0) begin
            if (wr_word == `PTPC_OFS_PORT_T_OUTPUT_VALUE) begin
                port_t_output_value <= wr_data[3:0];
            end else if (wr_word == `PTPC_OFS_PORT_T_DIRECTION) begin
                port_t_direction <= wr_data[3:0];
            end else if (wr_word == `PTPC_OFS_PIN_MISC_CONTROL) begin
                overcurrent_detect_enable <= wr_data[`PTPC_BIT_OVERCURRENT_ENABLE]; // RULE_01
            end else if (wr_word == `PTPC_OFS_EXT_IRQ_CONTROL) begin
                ext_irq_connect <= wr_data[`PTPC_BIT_IRQ_CONNECT]; // RULE_05
                if (SPECIAL_MODE_IN || !ext_irq_edge_written) begin
                    ext_irq_edge_select  <= wr_data[`PTPC_BIT_IRQ_EDGE_SELECT]; // RULE_06
                    ext_irq_edge_written <= 1'b1;
                end
            end else if (wr_word == `PTPC_OFS_FACTORY_TEST) begin
                if (SPECIAL_MODE_IN) begin
                    factory_test <= wr_data[7:0]; // RULE_17
                end
            end
        end
    end

    // ====================
    // AXI4-Lite read channel

    reg [31:0] next_rdata;
    wire [11:0] rd_word = {S_AXI_ARADDR_IN[11:2], 2'b00};
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;

    always @* begin
        next_rdata = 32'h00000000;
        if (rd_word == `PTPC_OFS_PORT_T_OUTPUT_VALUE) begin
            next_rdata[3:0] = (port_t_direction & port_t_output_value) |
                              (~port_t_direction & pin_sync); // RULE_07
        end else if (rd_word == `PTPC_OFS_PORT_T_DIRECTION) begin
            next_rdata[3:0] = port_t_direction;
        end else if (rd_word == `PTPC_OFS_PIN_MISC_CONTROL) begin
            next_rdata[`PTPC_BIT_OVERCURRENT_ENABLE] = overcurrent_detect_enable;
        end else if (rd_word == `PTPC_OFS_EXT_IRQ_CONTROL) begin
            next_rdata[`PTPC_BIT_IRQ_EDGE_SELECT] = ext_irq_edge_select;
            next_rdata[`PTPC_BIT_IRQ_CONNECT]     = ext_irq_connect;
        end else if (rd_word == `PTPC_OFS_FACTORY_TEST) begin
            next_rdata[7:0] = factory_test;
        end else if (rd_word == `PTPC_OFS_EXT_IRQ_STATUS) begin
            next_rdata[`PTPC_BIT_IRQ_PENDING] = ext_irq_pending;
        end
    end

    // Read data is registered so software always sees a clocked value.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT  <= 32'h00000000;
            S_AXI_RRESP_OUT  <= `PTPC_RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RDATA_OUT  <= next_rdata; // RULE_19
            S_AXI_RRESP_OUT  <= addr_known(rd_word) ? `PTPC_RESP_OKAY : `PTPC_RESP_SLVERR;
        end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
        end
    end
endmodule

/* File: sim/ptpc_chk_assertions.sv */
// Purpose: Port-level checker for the port T pin control block.
// Assumes: One clock domain; reset is synchronous and active high.
// Notes:   Priority checks are sampled at each edge.
`timescale 1ns/1ns
`include "ptpc_map.vh"

module ptpc_chk (
    input wire        CLOCK_IN,
    input wire        SYS_RST_IN,
    input wire [11:0] S_AXI_AWADDR_IN,
    input wire        S_AXI_AWVALID_IN,
    input wire        S_AXI_AWREADY_OUT,
    input wire [31:0] S_AXI_WDATA_IN,
    input wire [3:0]  S_AXI_WSTRB_IN,
    input wire        S_AXI_WVALID_IN,
    input wire        S_AXI_WREADY_OUT,
    input wire        S_AXI_BVALID_OUT,
    input wire        S_AXI_ARVALID_IN,
    input wire        S_AXI_ARREADY_OUT,
    input wire        S_AXI_RVALID_OUT,
    input wire [3:0]  PORT_T_PIN_IN,
    input wire [3:0]  PORT_T_PIN_OUT,
    input wire [3:0]  PORT_T_PIN_OE_OUT,
    input wire [3:2]  SPI_ENABLE_IN,
    input wire [3:2]  SPI_DRIVE_IN,
    input wire [3:2]  SPI_LEVEL_IN,
    input wire [3:2]  SPI_PIN_OUT,
    input wire [3:2]  LIN_TRANSCEIVER_ROUTE_IN,
    input wire [3:2]  LIN_DRIVE_IN,
    input wire [3:2]  LIN_LEVEL_IN,
    input wire [1:0]  SERIAL_IFACE_ZERO_ROUTE_IN,
    input wire [1:0]  SERIAL_IFACE_ZERO_DRIVE_IN,
    input wire [1:0]  SERIAL_IFACE_ZERO_LEVEL_IN,
    input wire [3:0]  LIN_RECEIVE_PATH_IN,
    input wire [3:0]  TIMER_CHANNEL_CAPTURE_OUT,
    input wire        OVERCURRENT_DETECT_ENABLE_OUT
);
    // ====================
    // Helper logic
    reg  [1:0] up;
    wire [3:2] spi_bad = SPI_ENABLE_IN & ((PORT_T_PIN_OE_OUT[3:2] ^ SPI_DRIVE_IN)
                         | (SPI_DRIVE_IN & (PORT_T_PIN_OUT[3:2] ^ SPI_LEVEL_IN)));
    wire [3:2] lin_bad = LIN_TRANSCEIVER_ROUTE_IN & ~SPI_ENABLE_IN
                         & ((PORT_T_PIN_OE_OUT[3:2] ^ LIN_DRIVE_IN)
                         | (LIN_DRIVE_IN & (PORT_T_PIN_OUT[3:2] ^ LIN_LEVEL_IN)));
    wire [1:0] ser_bad = SERIAL_IFACE_ZERO_ROUTE_IN
                         & ((PORT_T_PIN_OE_OUT[1:0] ^ SERIAL_IFACE_ZERO_DRIVE_IN)
                         | (SERIAL_IFACE_ZERO_DRIVE_IN
                         & (PORT_T_PIN_OUT[1:0] ^ SERIAL_IFACE_ZERO_LEVEL_IN)));

    // Synchroniser delay is judged only after reset.
    always @(posedge CLOCK_IN) begin
        if (SYS_RST_IN)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // ====================
    // Sequences and properties
    sequence s_wr;
        S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
    endsequence
    sequence s_rd;
        S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
    endsequence
    property p_wr;
        s_wr |=> S_AXI_BVALID_OUT;
    endproperty
    property p_rd;
        s_rd |=> S_AXI_RVALID_OUT;
    endproperty
    property p_ocp;
        s_wr ##0 (S_AXI_AWADDR_IN == `PTPC_OFS_PIN_MISC_CONTROL && S_AXI_WSTRB_IN[0])
            |=> OVERCURRENT_DETECT_ENABLE_OUT == $past(S_AXI_WDATA_IN[7]);
    endproperty
    property p_spi;
        spi_bad == 2'h0;
    endproperty
    property p_lin;
        lin_bad == 2'h0;
    endproperty
    property p_ser;
        ser_bad == 2'h0;
    endproperty
    property p_sync;
        up == 2'h3 |-> SPI_PIN_OUT == $past(PORT_T_PIN_IN[3:2], 2);
    endproperty
    property p_cap;
        (LIN_RECEIVE_PATH_IN & TIMER_CHANNEL_CAPTURE_OUT) == 4'h0;
    endproperty

    a_wr: assert property (p_wr)
        else $error("write response late");
    a_rd: assert property (p_rd)
        else $error("read response late");
    a_ocp: assert property (p_ocp)
        else $error("detector enable wrong");
    a_spi: assert property (p_spi)
        else $error("spi does not own pin");
    a_lin: assert property (p_lin)
        else $error("lin route does not own pin");
    a_ser: assert property (p_ser)
        else $error("serial route does not own pin");
    a_sync: assert property (p_sync)
        else $error("pin level not two stages late");
    a_cap: assert property (p_cap)
        else $error("capture seen on receive path pin");
endmodule

bind ptpc_top ptpc_chk i_ptpc_chk (.*);

/* File: sim/ptpc_far.sv */
// Purpose: Far-side pin model for the port T pins.
// Assumes: An external driver holds every pin that the block releases.
// Notes:   No pull devices are modelled.
`timescale 1ns/1ns

module ptpc_far (
    input  wire [3:0] oe_in,
    input  wire [3:0] drv_in,
    input  wire [3:0] ext_in,
    output wire [3:0] pin_out
);
    // The external level changes each test so a released pin never echoes the block.
    assign pin_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

/* File: sim/ptpc_top_tb.sv */
// Purpose: Self-checking bench for the port T pin control block.
// Assumes: Tasks act as AXI4-Lite master; pin levels come from ptpc_far.
// Notes:   Pin priority of the SPI, LIN and serial routes is judged by the checker.
`timescale 1ns/1ns
`include "ptpc_map.vh"

module ptpc_top_tb;
    // ====================
    // Signals
    reg         clk, rst, spec, awv, wv, brdy, arv, rrdy, irq, svc, ldle, ldl;
    reg  [11:0] awa, ara;
    reg  [31:0] wd, rdat;
    reg  [3:0]  ext, tce, tcv, pwe, pwl, hs, ls, lrx, m, d;
    reg  [3:2]  spe, spd, spl, lnr, lnd, lnl;
    reg  [1:0]  sr, sd, sl, bres, rres;
    wire        awr, wrd, arr, bv, rv, irq_req, ocp;
    wire [1:0]  br, rr;
    wire [31:0] rd_d;
    wire [3:0]  pin, pout, poe, cap;
    integer     seed, n_fail, comparisons, cyc, i;

    ptpc_top i_ptpc_top (
        .CLOCK_IN(clk), .SYS_RST_IN(rst), .SPECIAL_MODE_IN(spec),
        .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
        .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wrd), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
        .S_AXI_BREADY_IN(brdy), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd_d), .S_AXI_RRESP_OUT(rr),
        .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rrdy), .PORT_T_PIN_IN(pin),
        .PORT_T_PIN_OUT(pout), .PORT_T_PIN_OE_OUT(poe), .SPI_ENABLE_IN(spe),
        .SPI_DRIVE_IN(spd), .SPI_LEVEL_IN(spl), .SPI_PIN_OUT(),
        .LIN_TRANSCEIVER_ROUTE_IN(lnr), .LIN_DRIVE_IN(lnd), .LIN_LEVEL_IN(lnl),
        .LIN_PIN_OUT(), .SERIAL_IFACE_ZERO_ROUTE_IN(sr), .SERIAL_IFACE_ZERO_DRIVE_IN(sd),
        .SERIAL_IFACE_ZERO_LEVEL_IN(sl), .SERIAL_IFACE_ZERO_PIN_OUT(),
        .LIN_DRIVER_LEVEL_BIT_ENABLE_IN(ldle), .LIN_DRIVER_LEVEL_BIT_IN(ldl),
        .TIMER_CHANNEL_COMPARE_EN_IN(tce), .TIMER_CHANNEL_COMPARE_IN(tcv),
        .TIMER_CHANNEL_CAPTURE_OUT(cap), .PWM_ENABLE_IN(pwe), .PWM_LEVEL_IN(pwl),
        .HIGH_SIDE_DRIVER_ROUTE_IN(hs), .LOW_SIDE_DRIVER_ROUTE_IN(ls),
        .LIN_RECEIVE_PATH_IN(lrx), .EXT_IRQ_PIN_IN(irq), .EXT_IRQ_SERVICE_IN(svc),
        .EXT_IRQ_REQUEST_OUT(irq_req), .OVERCURRENT_DETECT_ENABLE_OUT(ocp)
    );
    ptpc_far i_ptpc_far (.oe_in(poe), .drv_in(pout), .ext_in(ext), .pin_out(pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 32'h0000_4E20) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end

    // ====================
    // Tasks and expectations
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("unexpected %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task wr(input [11:0] a, input [31:0] v);
        reg pa, pw;
        begin
            @(posedge clk);
            awa <= a;
            wd <= v;
            awv <= 1'b1;
            wv <= 1'b1;
            brdy <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            while (pa || pw) begin
                @(posedge clk);
                if (pa && awr === 1'b1) begin
                    pa = 1'b0;
                    awv <= 1'b0;
                end
                if (pw && wrd === 1'b1) begin
                    pw = 1'b0;
                    wv <= 1'b0;
                end
            end
            @(posedge clk);
            while (bv !== 1'b1)
                @(posedge clk);
            bres = br;
            brdy <= 1'b0;
        end
    endtask

    task rd(input [11:0] a);
        begin
            @(posedge clk);
            ara <= a;
            arv <= 1'b1;
            rrdy <= 1'b1;
            @(posedge clk);
            while (arr !== 1'b1)
                @(posedge clk);
            arv <= 1'b0;
            @(posedge clk);
            while (rv !== 1'b1)
                @(posedge clk);
            rdat = rd_d;
            rres = rr;
            rrdy <= 1'b0;
        end
    endtask

    task rchk(input string nm, input [11:0] a, input [31:0] e);
        begin
            rd(a);
            chk(nm, e, rdat);
        end
    endtask

    task wait_irq(input [31:0] e);
        begin
            repeat (4) @(posedge clk);
            chk("irq request", e, 32'(irq_req));
        end
    endtask

    function [31:0] port_read(input [3:0] dv, input [3:0] dir, input [3:0] lvl);
        port_read = {28'h0, (dv & dir) | (lvl & ~dir)};
    endfunction

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    // ====================
    // Main sequence
    initial begin
        seed = 32'h3848;
        n_fail = 0;
        comparisons = 0;
        cyc = 0;
        rst = 1'b1;
        irq = 1'b1;
        {spec, awv, wv, brdy, arv, rrdy, svc, ldle, ldl} = '0;
        {awa, ara, wd, ext, tce, tcv, pwe, pwl, hs, ls, lrx, m, d} = '0;
        {spe, spd, spl, lnr, lnd, lnl, sr, sd, sl} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
            rchk("reset", 12'(`PTPC_OFS_PORT_T_OUTPUT_VALUE + 4 * i), 32'h0);
        rd(12'h258);
        chk("read resp", 32'(`PTPC_RESP_SLVERR), 32'(rres));
        wr(12'h300, 32'hFF);
        chk("write resp", 32'(`PTPC_RESP_SLVERR), 32'(bres));
        $display("test map finished");
        wr(`PTPC_OFS_PIN_MISC_CONTROL, 32'hFFFF_FF80);
        chk("ocp enable", 32'h1, 32'(ocp));
        rchk("misc", `PTPC_OFS_PIN_MISC_CONTROL, 32'h80);
        wr(`PTPC_OFS_PIN_MISC_CONTROL, 32'h7F);
        chk("ocp enable", 32'h0, 32'(ocp));
        $display("test misc finished");
        for (i = 0; i < 24; i = i + 1) begin
            m = (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($random(seed));
            d = 4'($random(seed));
            wr(`PTPC_OFS_PORT_T_DIRECTION, {28'h0, m});
            wr(`PTPC_OFS_PORT_T_OUTPUT_VALUE, {28'h0, d});
            ext <= 4'($random(seed));
            repeat (3) @(posedge clk);
            rchk("port data", `PTPC_OFS_PORT_T_OUTPUT_VALUE, port_read(d, m, ext));
            chk("pin enable", 32'(m), 32'(poe));
            chk("pin level", 32'(d & m), 32'(pout & m));
        end
        $display("test data path finished");
        wr(`PTPC_OFS_EXT_IRQ_CONTROL, 32'hC0);
        irq <= 1'b0;
        wait_irq(32'h1);
        irq <= 1'b1;
        wait_irq(32'h1);
        rchk("irq status", `PTPC_OFS_EXT_IRQ_STATUS, 32'h1);
        svc <= 1'b1;
        @(posedge clk);
        svc <= 1'b0;
        wait_irq(32'h0);
        wr(`PTPC_OFS_EXT_IRQ_CONTROL, 32'h80);
        rchk("irq ctrl", `PTPC_OFS_EXT_IRQ_CONTROL, 32'h80);
        irq <= 1'b0;
        wait_irq(32'h0);
        irq <= 1'b1;
        wr(`PTPC_OFS_EXT_IRQ_CONTROL, 32'h40);
        wait_irq(32'h0);
        rchk("irq ctrl", `PTPC_OFS_EXT_IRQ_CONTROL, 32'hC0);
        spec <= 1'b1;
        wr(`PTPC_OFS_EXT_IRQ_CONTROL, 32'h40);
        rchk("irq ctrl", `PTPC_OFS_EXT_IRQ_CONTROL, 32'h40);
        irq <= 1'b0;
        wait_irq(32'h1);
        irq <= 1'b1;
        wait_irq(32'h0);
        $display("test interrupt finished");
        wr(`PTPC_OFS_FACTORY_TEST, 32'h5A);
        rchk("factory", `PTPC_OFS_FACTORY_TEST, 32'h5A);
        spec <= 1'b0;
        wr(`PTPC_OFS_FACTORY_TEST, 32'hA5);
        rchk("factory", `PTPC_OFS_FACTORY_TEST, 32'h5A);
        $display("test factory finished");
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge clk);
            {spe, spd, spl, lnr, lnd, lnl} <= 12'($random(seed));
            {sr, sd, sl, ldle, ldl} <= 8'($random(seed));
            {tce, tcv, pwe, pwl} <= 16'($random(seed));
            {hs, ls, lrx, ext} <= 16'($random(seed));
            repeat (3) @(posedge clk);
            chk("capture", 32'(pin & ~lrx), 32'(cap));
        end
        $display("test peripherals finished");
        tally_and_finish;
    end
endmodule
